// *** nies_pkg.sv ***
`default_nettype none
// ****************************************
// Shared constants
// ****************************************
package nies_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ID_LO = 8'h04;
    localparam logic [7:0] OFF_ID_HI = 8'h08;
    localparam logic [7:0] OFF_CB_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_POSITION = 8'h18;
    // Control fields and reset value (x8, two planes of 1Gb)
    localparam int CTRL_WORD_ORG = 0;
    localparam int CTRL_PLANES_LSB = 2;
    localparam int CTRL_PSIZE_LSB = 4;
    localparam logic [6:0] CTRL_RESET = 7'h44;
    // Bus commands
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_LOAD = 8'h80;
    localparam logic [7:0] CMD_CB_LOAD = 8'h85;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_CB_STATUS = 8'h7b;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    // Identification bytes three and four
    localparam logic [7:0] ID_BYTE3 = 8'h10;
    localparam logic [7:0] ID_BYTE4_X8 = 8'h95;
    localparam logic [7:0] ID_BYTE4_X16 = 8'hd5;
    localparam logic [2:0] ID_LAST = 3'h4;
    // Page geometry per organisation
    localparam logic [11:0] MAIN_X8 = 12'h800;
    localparam logic [11:0] PAGE_X8 = 12'h840;
    localparam logic [11:0] MAIN_X16 = 12'h400;
    localparam logic [11:0] PAGE_X16 = 12'h420;
    // Bus mode, Gray coded along the usual path
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_LOAD = 3'b001,
        M_OUT = 3'b011,
        M_ID = 3'b010,
        M_STAT = 3'b110,
        M_CBSTAT = 3'b111
    } nies_mode_t;
endpackage
`default_nettype wire

// *** nies_top.sv ***
// The APB interface to the registers and the register offsets were decided locally.
`default_nettype none
// Functional notes
// - Fifth ID byte: planes in 3:2, plane size in 6:4, bits 7,1,0 zero.
// - x8 page is four 528-byte sectors: 512 main plus 16 spare.
// - x16 page is four 264-word sectors: 256 main plus 8 spare.
// - Copy-back status: bit0 fail, bit1 check error, bits 3,4 don't care.
// - Copy-back status bit2 says the check outcome is valid.
// - Copy-back status bits 5 and 6 are zero busy, one ready.
// - Copy-back status bit7 is zero while write protected.
// - Chip enable is ignored during data loading and sequential read-out.
// - Read-out stops at page end; no advance into the next page.
// - Full x8 page load is 2112 data cycles; more are ignored.
// - Read ID returns five bytes: maker, device, third, fourth, fifth.
module nies_top #(
    parameter logic [7:0] MAKER_CODE = 8'h5a,  // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h3c  // Arbitrary value
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Flash bus pins
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic wp_n,
    input wire logic [15:0] io_in,
    output logic [15:0] io_out,
    output logic io_oe,
    // Array side
    output logic [11:0] col,
    output logic [1:0] sector,
    output logic sector_spare,
    output logic load_valid,
    output logic [15:0] load_data,
    output logic prog_start,
    output logic prog_copyback,
    output logic read_start,
    input wire logic [15:0] rd_data,
    input wire logic array_busy,
    input wire logic array_fail,
    input wire logic check_error,
    input wire logic check_valid
);
    // ****************************************
    // Control register and derived values
    // ****************************************
    logic [6:0] ctrl;
    logic word_org;
    logic [7:0] id_fifth;
    logic [7:0] cb_status;
    logic [11:0] page_len;
    logic [11:0] main_len;
    logic cb_done;
    assign word_org = ctrl[nies_pkg::CTRL_WORD_ORG];
    assign page_len = word_org ? nies_pkg::PAGE_X16 : nies_pkg::PAGE_X8;
    assign main_len = word_org ? nies_pkg::MAIN_X16 : nies_pkg::MAIN_X8;
    // Reserved bits forced to zero around the two fields
    assign id_fifth = {1'b0, ctrl[nies_pkg::CTRL_PSIZE_LSB +: 3],
                       ctrl[nies_pkg::CTRL_PLANES_LSB +: 2], 2'b00};
    // Don't-care bits 3 and 4 read as zero
    assign cb_status = {wp_n,
                        ~array_busy, ~array_busy,
                        2'b00,
                        check_valid & cb_done & ~array_busy,
                        check_error, array_fail};
    // ****************************************
    // Bus strobe edges
    // ****************************************
    logic we_n_q;
    logic rs_n_q;
    logic we_rise;
    logic rs_fall;
    // Pins are synchronous; one stage of history gives the edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            we_n_q <= 1'b1;
            rs_n_q <= 1'b1;
        end
        else
        begin
            we_n_q <= we_n;
            rs_n_q <= read_strobe_n;
        end
    end
    assign we_rise = we_n & ~we_n_q;
    assign rs_fall = ~read_strobe_n & rs_n_q;
    // ****************************************
    // Command, address and mode
    // ****************************************
    nies_pkg::nies_mode_t mode;
    logic [2:0] id_idx;
    logic [1:0] addr_cnt;
    logic cmd_we;
    logic addr_we;
    logic data_we;
    logic [11:0] next_col;
    // Command and address need chip enable; data cycles do not
    assign cmd_we = we_rise & cle & ~ale & ~ce_n;
    assign addr_we = we_rise & ale & ~cle & ~ce_n;
    assign data_we = we_rise & ~cle & ~ale & (mode == nies_pkg::M_LOAD);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode <= nies_pkg::M_IDLE;
            prog_copyback <= 1'b0;
            cb_done <= 1'b0;
        end
        else if (cmd_we)
        begin
            unique case (io_in[7:0])
                nies_pkg::CMD_LOAD:
                begin
                    mode <= nies_pkg::M_LOAD;
                    prog_copyback <= 1'b0;
                end
                nies_pkg::CMD_CB_LOAD:
                begin
                    mode <= nies_pkg::M_LOAD;
                    prog_copyback <= 1'b1;
                    cb_done <= 1'b0;
                end
                nies_pkg::CMD_PROG_GO:
                begin
                    mode <= nies_pkg::M_IDLE;
                    cb_done <= prog_copyback;
                end
                nies_pkg::CMD_READ_GO: mode <= nies_pkg::M_OUT;
                nies_pkg::CMD_READ_ID: mode <= nies_pkg::M_ID;
                nies_pkg::CMD_STATUS: mode <= nies_pkg::M_STAT;
                nies_pkg::CMD_CB_STATUS: mode <= nies_pkg::M_CBSTAT;
                default: mode <= nies_pkg::M_IDLE;
            endcase
        end
    end
    // Two column cycles set the column; row cycles are left to the array
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_cnt <= 2'b00;
            col <= 12'h000;
        end
        else if (cmd_we)
            addr_cnt <= 2'b00;
        else if (addr_we)
        begin
            if (addr_cnt == 2'b00)
                col <= {col[11:8], io_in[7:0]};
            else if (addr_cnt == 2'b01)
                col <= {io_in[3:0], col[7:0]};
            if (addr_cnt != 2'b11)
                addr_cnt <= addr_cnt + 2'b01;
        end
        else
            col <= next_col;
    end
    // Column stops at the page end instead of rolling into the next page
    always_comb
    begin
        next_col = col;
        if ((data_we || (rs_fall && mode == nies_pkg::M_OUT)) && col < page_len)
            next_col = col + 12'h001;
    end

    // ****************************************
    // Sector mapping
    // ****************************************
    logic [11:0] spare_off;
    // Main slices are 512 bytes or 256 words, spares 16 bytes or 8 words
    always_comb
    begin
        spare_off = col - main_len;
        sector_spare = col >= main_len;
        if (word_org)
            sector = sector_spare ? spare_off[4:3] : col[9:8];
        else
            sector = sector_spare ? spare_off[5:4] : col[10:9];
    end

    // ****************************************
    // Data path to the array
    // ****************************************
    // Cycles beyond the full page length are dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            load_valid <= 1'b0;
            load_data <= 16'h0000;
        end
        else
        begin
            load_valid <= data_we && col < page_len;
            if (data_we)
                load_data <= word_org ? io_in : {8'h00, io_in[7:0]};
        end
    end
    // Start pulses for the array
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prog_start <= 1'b0;
            read_start <= 1'b0;
        end
        else
        begin
            prog_start <= cmd_we && io_in[7:0] == nies_pkg::CMD_PROG_GO;
            read_start <= cmd_we && io_in[7:0] == nies_pkg::CMD_READ_GO;
        end
    end

    // ****************************************
    // Read-out
    // ****************************************
    logic out_mode;
    assign out_mode = mode != nies_pkg::M_IDLE && mode != nies_pkg::M_LOAD;
    // Output is driven by the strobe alone, so chip enable may idle high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            io_out <= 16'h0000;
            io_oe <= 1'b0;
            id_idx <= 3'h0;
        end
        else
        begin
            io_oe <= out_mode & ~read_strobe_n;
            if (cmd_we)
                id_idx <= 3'h0;
            else if (rs_fall)
            begin
                unique case (mode)
                    nies_pkg::M_ID:
                    begin
                        unique case (id_idx)
                            3'h0: io_out <= {8'h00, MAKER_CODE};
                            3'h1: io_out <= {8'h00, DEVICE_CODE};
                            3'h2: io_out <= {8'h00, nies_pkg::ID_BYTE3};
                            3'h3: io_out <= {8'h00, word_org ? nies_pkg::ID_BYTE4_X16
                                                             : nies_pkg::ID_BYTE4_X8};
                            default: io_out <= {8'h00, id_fifth};
                        endcase
                        if (id_idx != nies_pkg::ID_LAST)
                            id_idx <= id_idx + 3'h1;
                    end
                    nies_pkg::M_STAT:
                        io_out <= {8'h00, wp_n, ~array_busy, ~array_busy, 4'h0, array_fail};
                    nies_pkg::M_CBSTAT: io_out <= {8'h00, cb_status};
                    nies_pkg::M_OUT:
                        io_out <= col < page_len ? rd_data : 16'hffff;
                    default: io_out <= io_out;
                endcase
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] irq_event;
    logic rd_irq;
    // Program issued, read issued, load past the page end
    assign irq_event = {data_we && col >= page_len, read_start, prog_start};
    assign rd_irq = psel & penable & ~pwrite & paddr == nies_pkg::OFF_IRQ_STATUS;
    // Read clears, but a same-cycle event stays set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status <= 3'h0;
        else
            irq_status <= (rd_irq ? 3'h0 : irq_status) | irq_event;
    end
    assign irq = |(irq_status & irq_mask);
    // ****************************************
    // APB slave
    // ****************************************
    logic wr_en;
    // Zero wait states; unmapped reads give zero, writes to them are dropped
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite;
    // Writable control and mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= nies_pkg::CTRL_RESET;
            irq_mask <= 3'h0;
        end
        else if (wr_en)
        begin
            if (paddr == nies_pkg::OFF_CTRL)
                ctrl <= pwdata[6:0];
            if (paddr == nies_pkg::OFF_IRQ_MASK)
                irq_mask <= pwdata[2:0];
        end
    end
    // Read mux
    always_comb
    begin
        unique case (paddr)
            nies_pkg::OFF_CTRL: prdata = {25'h0, ctrl};
            nies_pkg::OFF_ID_LO: prdata = {word_org ? nies_pkg::ID_BYTE4_X16
                                                    : nies_pkg::ID_BYTE4_X8,
                                           nies_pkg::ID_BYTE3, DEVICE_CODE, MAKER_CODE};
            nies_pkg::OFF_ID_HI: prdata = {24'h0, id_fifth};
            nies_pkg::OFF_CB_STATUS: prdata = {24'h0, cb_status};
            nies_pkg::OFF_IRQ_STATUS: prdata = {29'h0, irq_status};
            nies_pkg::OFF_IRQ_MASK: prdata = {29'h0, irq_mask};
            nies_pkg::OFF_POSITION: prdata = {13'h0, sector_spare, sector, col, 1'b0, mode};
            default: prdata = 32'h0;
        endcase
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_fifth_reserved: assert property (id_fifth[7] == 1'b0 && id_fifth[1:0] == 2'b00)
        else $error("fifth id byte reserved bits set");
    a_x8_sector: assert property (!word_org && col >= 12'h810 && col < 12'h820
                                  |-> sector == 2'h1 && sector_spare)
        else $error("x8 spare sector map wrong");
    a_x16_sector: assert property (word_org && col >= 12'h300 && col < 12'h400
                                   |-> sector == 2'h3 && !sector_spare)
        else $error("x16 main sector map wrong");
    a_cb_fail_bit: assert property (cb_status[0] == array_fail && cb_status[4:3] == 2'b00)
        else $error("copy-back fail bit wrong");
    a_cb_valid: assert property (array_busy |-> !cb_status[2])
        else $error("check outcome valid while busy");
    a_ready_bits: assert property (cb_status[6:5] == {2{~array_busy}})
        else $error("ready bits wrong");
    a_wp_bit: assert property (cb_status[7] == wp_n)
        else $error("write protect bit wrong");
    a_load_no_ce: assert property (data_we && col < page_len |=> load_valid)
        else $error("load cycle lost");
    a_no_advance: assert property (col == page_len && !addr_we |=> col == page_len)
        else $error("column advanced past page end");
    a_page_cap: assert property (load_valid |-> $past(col) < page_len)
        else $error("load accepted past full page");
    a_id_first: assert property (cmd_we && io_in[7:0] == nies_pkg::CMD_READ_ID
                                 |=> id_idx == 3'h0 && mode == nies_pkg::M_ID)
        else $error("id sequence not restarted");
    c_full_load: cover property (load_valid && $past(col) == 12'h83f);
    c_id_fifth: cover property (mode == nies_pkg::M_ID && id_idx == nies_pkg::ID_LAST && rs_fall);
    c_cb_status: cover property (mode == nies_pkg::M_CBSTAT && rs_fall && cb_status[2]);
endmodule // nies_top
`default_nettype wire

// *** nies_host_model.sv ***
`default_nettype none
// ****************************************
// Host controller model on the flash bus
// ****************************************
module nies_host_model (
    // Clock
    input wire logic pclk,
    // Flash bus pins
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_n,
    output logic [15:0] io_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus, deselected
    initial
    begin
        ce_n = 1'b1;
        cle = 1'b0;
        ale = 1'b0;
        we_n = 1'b1;
        read_strobe_n = 1'b1;
        io_in = 16'h0000;
    end

    // One latch cycle; everything held until the write strobe rise is sampled
    task automatic wr(input logic c, input logic a, input logic [15:0] d, input logic ce);
        @(posedge pclk);
        cle <= c;
        ale <= a;
        io_in <= d;
        ce_n <= ce;
        we_n <= 1'b0;
        repeat (2) @(posedge pclk);
        we_n <= 1'b1;
        @(posedge pclk);
        io_in <= ~d;  // Released bus never shows the old value
        cle <= 1'b0;
        ale <= 1'b0;
        ce_n <= 1'b1;
    endtask

    // Command cycle, chip selected
    task automatic cmd(input logic [7:0] c);
        wr(1'b1, 1'b0, {8'h00, c}, 1'b0);
    endtask

    // Two column cycles then three row cycles
    task automatic adr(input logic [11:0] c);
        wr(1'b0, 1'b1, {8'h00, c[7:0]}, 1'b0);
        wr(1'b0, 1'b1, {12'h000, c[11:8]}, 1'b0);
        repeat (3) wr(1'b0, 1'b1, 16'h0000, 1'b0);
    endtask

    // Read strobe, low two clocks, high one
    task automatic rd(input logic ce);
        @(posedge pclk);
        ce_n <= ce;
        read_strobe_n <= 1'b0;
        repeat (2) @(posedge pclk);
        read_strobe_n <= 1'b1;
        @(posedge pclk);
        ce_n <= 1'b1;
    endtask
endmodule  // nies_host_model
`default_nettype wire

// *** nies_ident_errcheck_status_bench.sv ***
`default_nettype none
module nand_ident_errcheck_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h5a;  // Arbitrary value
    localparam logic [7:0] DEVICE = 8'h3c;  // Arbitrary value
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, m;
    logic pready, pslverr, irq, ce_n, cle, ale, we_n, read_strobe_n, io_oe;
    logic wp_n = 1'b1, array_fail = 1'b0, check_error = 1'b0, check_valid = 1'b0;
    logic [15:0] io_in, io_out, rd_data, load_data;
    logic [11:0] col;
    logic [1:0] sector;
    logic sector_spare, load_valid, prog_start, prog_copyback, read_start, rs_q = 1'b1;
    wire logic array_busy;
    logic [5:0] busy_cnt = 6'h00;
    logic [11:0] cols [17] = '{12'h000, 12'h1ff, 12'h200, 12'h5ff, 12'h600, 12'h7ff,
        12'h800, 12'h80f, 12'h810, 12'h83f, 12'h0ff, 12'h100, 12'h3ff, 12'h400,
        12'h407, 12'h408, 12'h41f};
    int n_errors = 0, checks = 0, n_load = 0;
    logic [31:0] apb_q[$], io_q[$];  // io notes carry {mask, expected}

    nies_top #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) nies_top_i (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .ce_n, .cle, .ale, .we_n, .read_strobe_n, .wp_n, .io_in, .io_out, .io_oe, .col,
        .sector, .sector_spare, .load_valid, .load_data, .prog_start, .prog_copyback,
        .read_start, .rd_data, .array_busy, .array_fail, .check_error, .check_valid);
    nies_host_model nies_host_model_i (.pclk, .ce_n, .cle, .ale, .we_n, .read_strobe_n,
        .io_in);

    // ****************************************
    // Clock and array model
    // ****************************************
    always #2 pclk = ~pclk;
    // Array data follows the column; busy for forty clocks after each start
    assign rd_data = {4'ha, col};
    assign array_busy = (busy_cnt != 6'h00);
    always @(posedge pclk)
        if (prog_start === 1'b1 || read_start === 1'b1)
            busy_cnt <= 6'h28;
        else if (busy_cnt != 6'h00)
            busy_cnt <= busy_cnt - 6'h01;

    // ****************************************
    // Checking
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Watchers take the oldest note once a result shows
    always @(posedge pclk)
    begin
        rs_q <= read_strobe_n;
        if (load_valid === 1'b1)
            n_load++;
        if (psel && penable && pready === 1'b1 && !pwrite && apb_q.size() > 0)
            chk(prdata, apb_q.pop_front());
        if (read_strobe_n === 1'b1 && rs_q === 1'b0 && io_q.size() > 0)
        begin
            m = io_q.pop_front();
            chk({16'h0, io_out & m[31:16]}, {16'h0, m[15:0]});
        end
    end

    task automatic close_out;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************************************
    // Bus tasks
    // ****************************************
    // APB transfer; request held until pready is sampled, only the watchdog ends a wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, input logic [31:0] e);
        apb_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // Flash read strobe with chip enable at random
    task automatic ior(input logic [15:0] mk, input logic [15:0] e);
        io_q.push_back({mk, e & mk});
        nies_host_model_i.rd(1'($urandom));
    endtask

    function automatic logic [2:0] sec_exp(input logic x16, input logic [11:0] c);
        if (x16)
            return (c < 12'h400) ? {1'b0, c[9:8]} : {1'b1, c[4:3]};
        return (c < 12'h800) ? {1'b0, c[10:9]} : {1'b1, c[5:4]};
    endfunction

    // Watchdog, well past the expected run
    initial
    begin
        #200000;
        n_errors++;
        close_out;
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        logic [7:0] v;
        logic [47:0] id;
        logic [7:0] e;
        void'($urandom(94));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place
        rdr(nies_pkg::OFF_CTRL, {25'h0, nies_pkg::CTRL_RESET});
        rdr(nies_pkg::OFF_ID_HI, 32'h44);
        rdr(nies_pkg::OFF_IRQ_MASK, 32'h0);
        apb(1'b1, 8'h40, 32'hffffffff);
        rdr(8'h40, 32'h0);
        // Every plane count, random plane size, both widths
        for (int i = 0; i < 4; i++)
        begin
            v = {1'b0, 3'($urandom), i[1:0], 1'b0, i[0]};
            apb(1'b1, nies_pkg::OFF_CTRL, {24'h0, v});
            rdr(nies_pkg::OFF_ID_HI, {24'h0, v & 8'h7c});
            id = {MAKER, DEVICE, nies_pkg::ID_BYTE3,
                v[0] ? nies_pkg::ID_BYTE4_X16 : nies_pkg::ID_BYTE4_X8, v & 8'h7c, v & 8'h7c};
            nies_host_model_i.cmd(nies_pkg::CMD_READ_ID);
            for (int k = 5; k >= 0; k--)
                ior(16'h00ff, {8'h0, id[k*8 +: 8]});
        end
        // Sector boundaries, x8 then x16
        for (int i = 0; i < 17; i++)
        begin
            if (i == 0 || i == 10)
                apb(1'b1, nies_pkg::OFF_CTRL, (i == 0) ? 32'h44 : 32'h45);
            nies_host_model_i.cmd(nies_pkg::CMD_READ);
            nies_host_model_i.adr(cols[i]);
            repeat (2) @(posedge pclk);
            chk({29'h0, sector_spare, sector}, {29'h0, sec_exp(i >= 10, cols[i])});
        end
        // Read across the page end, interrupt masked
        apb(1'b1, nies_pkg::OFF_CTRL, 32'h44);
        nies_host_model_i.cmd(nies_pkg::CMD_READ);
        nies_host_model_i.adr(12'h83e);
        nies_host_model_i.cmd(nies_pkg::CMD_READ_GO);
        repeat (48) @(posedge pclk);
        ior(16'h00ff, 16'h003e);
        ior(16'h00ff, 16'h003f);
        ior(16'h00ff, 16'h00ff);
        ior(16'h00ff, 16'h00ff);
        chk({31'h0, irq}, 32'h0);
        rdr(nies_pkg::OFF_IRQ_STATUS, 32'h2);
        rdr(nies_pkg::OFF_IRQ_STATUS, 32'h0);
        // Full page load plus one surplus cycle, chip enable at random
        apb(1'b1, nies_pkg::OFF_IRQ_MASK, 32'h4);
        nies_host_model_i.cmd(nies_pkg::CMD_LOAD);
        nies_host_model_i.adr(12'h000);
        n_load = 0;
        for (int i = 0; i < 2113; i++)
            nies_host_model_i.wr(1'b0, 1'b0, 16'($urandom), 1'($urandom));
        repeat (2) @(posedge pclk);
        chk(n_load, 32'd2112);
        chk({31'h0, irq}, 32'h1);
        rdr(nies_pkg::OFF_IRQ_STATUS, 32'h4);
        nies_host_model_i.cmd(nies_pkg::CMD_PROG_GO);
        repeat (48) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rdr(nies_pkg::OFF_IRQ_STATUS, 32'h1);
        // Copy-back with random outcome; check bit trusted only when valid
        apb(1'b1, nies_pkg::OFF_IRQ_MASK, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom);
            array_fail <= v[0];
            check_valid <= v[2];
            check_error <= v[1] & v[2];
            nies_host_model_i.cmd(nies_pkg::CMD_CB_LOAD);
            nies_host_model_i.adr(12'h000);
            nies_host_model_i.cmd(nies_pkg::CMD_PROG_GO);
            chk({31'h0, prog_copyback}, 32'h1);
            nies_host_model_i.cmd(nies_pkg::CMD_CB_STATUS);
            ior(16'h0064, 16'h0000);
            repeat (48) @(posedge pclk);
            chk({31'h0, irq}, 32'h1);
            e = {3'b111, 2'b00, v[2], v[1] & v[2], v[0]};
            nies_host_model_i.cmd(nies_pkg::CMD_CB_STATUS);
            ior(16'h00ff, {8'h0, e});
            rdr(nies_pkg::OFF_CB_STATUS, {24'h0, e});
            rdr(nies_pkg::OFF_IRQ_STATUS, 32'h1);
        end
        // Write protected
        wp_n <= 1'b0;
        nies_host_model_i.cmd(nies_pkg::CMD_CB_STATUS);
        ior(16'h00e0, 16'h0060);
        repeat (4) @(posedge pclk);
        chk(32'(io_q.size() + apb_q.size()), 32'h0);
        close_out;
    end
endmodule  // nand_ident_errcheck_status_bench
`default_nettype wire
